// ### rtl/cdc_pkg.sv
// package: register map, field positions and reset values of the comparator control block
package cdc_pkg;
  // ---------------------------------------------------------------
  // register indices and byte addresses (each byte address is its index times four)
  // ---------------------------------------------------------------
  localparam logic [7:0] CDC_IDX_INTERRUPT_CONTROL_REG = 8'h0b;
  localparam logic [7:0] CDC_IDX_PFLAG = 8'h0c;
  localparam logic [7:0] CDC_IDX_CTRL = 8'h19;
  localparam logic [7:0] CDC_IDX_CFG = 8'h1a;
  localparam logic [7:0] CDC_IDX_DIR = 8'h85;
  localparam logic [7:0] CDC_IDX_PEN = 8'h8c;
  localparam logic [7:0] CDC_IDX_VREF = 8'h99;
  localparam logic [9:0] CDC_ADDR_INTERRUPT_CONTROL_REG = {CDC_IDX_INTERRUPT_CONTROL_REG, 2'b00};
  localparam logic [9:0] CDC_ADDR_PFLAG = {CDC_IDX_PFLAG, 2'b00};
  localparam logic [9:0] CDC_ADDR_CTRL = {CDC_IDX_CTRL, 2'b00};
  localparam logic [9:0] CDC_ADDR_CFG = {CDC_IDX_CFG, 2'b00};
  localparam logic [9:0] CDC_ADDR_DIR = {CDC_IDX_DIR, 2'b00};
  localparam logic [9:0] CDC_ADDR_PEN = {CDC_IDX_PEN, 2'b00};
  localparam logic [9:0] CDC_ADDR_VREF = {CDC_IDX_VREF, 2'b00};
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CDC_CFG_SYNC = 0;
  localparam int CDC_CFG_GSS = 1;
  localparam int CDC_CTRL_INV = 4;
  localparam int CDC_CTRL_RES = 6;
  localparam int CDC_CTRL_CIS = 3;
  localparam int CDC_PF_CMP = 3;
  localparam int CDC_PE_CMP = 3;
  localparam int CDC_IC_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int CDC_IC_GIE = 7;
  localparam int CDC_VR_EN = 7;
  localparam int CDC_VR_LOW = 5;
  localparam int CDC_DIR_PIN = 2;
  // ---------------------------------------------------------------
  // writable masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CDC_CFG_MASK = 8'h03;
  localparam logic [7:0] CDC_CTRL_MASK = 8'h1f;
  localparam logic [7:0] CDC_VREF_MASK = 8'haf;
  localparam logic [7:0] CDC_PF_MASK = 8'hef;
  localparam logic [7:0] CDC_PE_MASK = 8'hef;
  localparam logic [7:0] CDC_DIR_MASK = 8'h3f;
  localparam logic [7:0] CDC_CFG_RST = 8'h02;
  localparam logic [7:0] CDC_CTRL_RST = 8'h00;
  localparam logic [7:0] CDC_VREF_RST = 8'h00;
  localparam logic [7:0] CDC_DIR_RST = 8'h3f;
  localparam logic [7:0] CDC_ZERO_RST = 8'h00;
  localparam logic [2:0] CDC_MODE_RESET = 3'h0;
  localparam logic [2:0] CDC_MODE_OFF = 3'h7;
  localparam logic [15:0] CDC_WAKE_VECTOR = 16'h0004;
  // register bus request
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cdc_bus_t;
  // reference setting handed to the analog ladder
  typedef struct packed {
    logic power_on;
    logic low_range;
    logic [3:0] level_code;
    logic ground;
  } cdc_ref_t;
  typedef enum logic [1:0] {
    CDC_AWAKE = 2'b01,
    CDC_ASLEEP = 2'b10
  } cdc_pwr_t;
endpackage

// ### rtl/cdc_comparator_control.sv
// comparator digital control: polarity, sync latch, gate select, flag, reference, sleep wake
// Summary of operation
// - config bit 1 picks timer gate: 1 gate pin, 0 comparator result
// - sync enable clear: result reaches users unsynchronised
// - sync enable set: result latched on timer clock falling edge
// - config bits 7..2 read zero, writes ignored
// - result readable at control bit 6, writes do not touch it
// - output pin mode selects raw result instead of port latch
// - pin direction bit still gates the output driver
// - invert bit 4 flips result polarity for every consumer
// - flag bit 3 of peripheral flags sets when result changes
// - software clears flag writing 0, writing 1 sets it
// - request only with flag enable, peripheral and global enables set
// - mismatch keeps setting flag; control access ends the mismatch
// - change during control read may leave flag unset
// - reference 32 levels; level code and range go to ladder
// - reference off, code 0000, low range gives ground
// - comparator and reference stay active in sleep
// - flag event in sleep wakes when flag enable and peripheral enable are set; global enable picks vector
// - wake leaves control, config and reference registers unchanged
// - reset puts mode 000 and reference off
// - raw result 1 when inverting input below non-inverting
//
// Added by the designer: the strobed register port.
module cdc_comparator_control
  import cdc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire cdc_pkg::cdc_bus_t bus,
  output logic [7:0] rdata,
  // analog comparator core
  input wire logic cmp_raw,
  output logic [2:0] comparator_mode_code,
  output logic input_switch,
  output cdc_pkg::cdc_ref_t internal_reference_level,
  // timer one
  input wire logic timer_clk_prescaled,
  input wire logic timer_gate_pin,
  output logic timer_gate,
  output logic comparator_result,
  // result output pin
  input wire logic port_latch_bit,
  output logic result_output_pin,
  output logic result_output_pin_oe_n,
  output logic [5:0] pin_direction,
  // processor interface
  input wire logic sleep_req,
  output logic irq_req,
  output logic wake,
  output logic wake_vector_en,
  output logic asleep
);
  import cdc_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_q, cfg_q, vref_q, pflag_q, pen_q, interrupt_control_reg_q, dir_q;
  logic [7:0] rdata_q;
  logic tclk_q, sync_res_q, copy_q, pin_q;
  logic inv_res, res;
  logic mismatch, ctrl_touch, flag_wr, flag_set;
  cdc_pwr_t pwr_q;

  // polarity: invert bit applies to all consumers
  assign inv_res = cmp_raw ^ ctrl_q[CDC_CTRL_INV];

  // timer clock edge detect; latch result on falling edge after prescaler
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tclk_q <= 1'b0;
      sync_res_q <= 1'b0;
    end else begin
      tclk_q <= timer_clk_prescaled;
      if (tclk_q && !timer_clk_prescaled) begin
        sync_res_q <= inv_res;
      end
    end
  end

  // users see latched or direct result
  assign res = cfg_q[CDC_CFG_SYNC] ? sync_res_q : inv_res;
  assign comparator_result = res;
  assign timer_gate = cfg_q[CDC_CFG_GSS] ? timer_gate_pin : res;

  // pin mux: modes 001, 011 drive the raw inverted result, not synced
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else if (ctrl_q[2:0] == 3'h1 || ctrl_q[2:0] == 3'h3) begin
      pin_q <= inv_res;
    end else begin
      pin_q <= port_latch_bit;
    end
  end
  assign result_output_pin = pin_q;
  assign result_output_pin_oe_n = dir_q[CDC_DIR_PIN];
  assign pin_direction = dir_q[5:0];

  // ---------------------------------------------------------------
  // mismatch detection
  // ---------------------------------------------------------------
  // copy refreshed on every control access; a change landing exactly on
  // the access is absorbed into the copy, so the flag may stay unset
  assign ctrl_touch = (bus.rd || bus.wr) && bus.addr == CDC_ADDR_CTRL;
  assign mismatch = res != copy_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      copy_q <= 1'b0;
    end else if (ctrl_touch) begin
      copy_q <= res;
    end
  end
  assign flag_set = mismatch && !ctrl_touch;
  assign flag_wr = bus.wr && bus.addr == CDC_ADDR_PFLAG;

  // flag register: hardware set wins over a software clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pflag_q <= CDC_ZERO_RST;
    end else begin
      if (flag_wr) begin
        pflag_q <= bus.wdata & CDC_PF_MASK;
      end
      if (flag_set) begin
        pflag_q[CDC_PF_CMP] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // software registers; untouched by sleep or wake
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CDC_CTRL_RST;
      cfg_q <= CDC_CFG_RST;
      vref_q <= CDC_VREF_RST;
      pen_q <= CDC_ZERO_RST;
      interrupt_control_reg_q <= CDC_ZERO_RST;
      dir_q <= CDC_DIR_RST;
    end else if (bus.wr) begin
      unique case (bus.addr)
        CDC_ADDR_CTRL: ctrl_q <= bus.wdata & CDC_CTRL_MASK;
        CDC_ADDR_CFG: cfg_q <= bus.wdata & CDC_CFG_MASK;
        CDC_ADDR_VREF: vref_q <= bus.wdata & CDC_VREF_MASK;
        CDC_ADDR_PEN: pen_q <= bus.wdata & CDC_PE_MASK;
        CDC_ADDR_INTERRUPT_CONTROL_REG: interrupt_control_reg_q <= bus.wdata;
        CDC_ADDR_DIR: dir_q <= bus.wdata & CDC_DIR_MASK;
        default: ;
      endcase
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= CDC_ZERO_RST;
    end else if (bus.rd) begin
      unique case (bus.addr)
        CDC_ADDR_CTRL: rdata_q <= ctrl_q | {1'b0, res, 6'h00};
        CDC_ADDR_CFG: rdata_q <= cfg_q;
        CDC_ADDR_VREF: rdata_q <= vref_q;
        CDC_ADDR_PFLAG: rdata_q <= pflag_q;
        CDC_ADDR_PEN: rdata_q <= pen_q;
        CDC_ADDR_INTERRUPT_CONTROL_REG: rdata_q <= interrupt_control_reg_q;
        CDC_ADDR_DIR: rdata_q <= dir_q;
        default: rdata_q <= CDC_ZERO_RST;
      endcase
    end else begin
      rdata_q <= CDC_ZERO_RST;
    end
  end
  assign rdata = rdata_q;

  // analog controls
  assign comparator_mode_code = ctrl_q[2:0];
  assign input_switch = ctrl_q[CDC_CTRL_CIS];
  assign internal_reference_level.power_on = vref_q[CDC_VR_EN];
  assign internal_reference_level.low_range = vref_q[CDC_VR_LOW];
  assign internal_reference_level.level_code = vref_q[3:0];
  assign internal_reference_level.ground = !vref_q[CDC_VR_EN] &&
    vref_q[CDC_VR_LOW] && vref_q[3:0] == 4'h0;

  // interrupt request to processor
  assign irq_req = pflag_q[CDC_PF_CMP] && pen_q[CDC_PE_CMP] &&
    interrupt_control_reg_q[CDC_IC_PERIPHERAL_IRQ_ENABLE] && interrupt_control_reg_q[CDC_IC_GIE];

  // ---------------------------------------------------------------
  // sleep and wake; comparator logic keeps running while asleep
  // ---------------------------------------------------------------
  logic wake_cond;
  assign wake_cond = pflag_q[CDC_PF_CMP] && pen_q[CDC_PE_CMP] &&
    interrupt_control_reg_q[CDC_IC_PERIPHERAL_IRQ_ENABLE];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwr_q <= CDC_AWAKE;
    end else begin
      unique case (pwr_q)
        CDC_AWAKE: if (sleep_req) pwr_q <= CDC_ASLEEP;
        CDC_ASLEEP: if (wake_cond) pwr_q <= CDC_AWAKE;
        default: pwr_q <= CDC_AWAKE;
      endcase
    end
  end
  assign asleep = pwr_q == CDC_ASLEEP;
  assign wake = asleep && wake_cond;
  assign wake_vector_en = wake && interrupt_control_reg_q[CDC_IC_GIE];
endmodule

// ### testbench/cdc_sva.sv
// checker: port-level assertions for the comparator control block
module cdc_sva
  import cdc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire cdc_pkg::cdc_bus_t bus,
  input wire logic [7:0] rdata,
  // comparator and timer
  input wire logic cmp_raw,
  input wire logic [2:0] comparator_mode_code,
  input wire logic input_switch,
  input wire logic timer_gate_pin,
  input wire logic timer_clk_prescaled,
  input wire logic timer_gate,
  input wire logic comparator_result,
  // output pin
  input wire logic port_latch_bit,
  input wire logic result_output_pin,
  input wire logic result_output_pin_oe_n,
  input wire logic [5:0] pin_direction
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [1:0] cfg_q;
  logic inv_q;
  // shadow of config and invert bits; the checker sees them only through writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_q <= CDC_CFG_RST[1:0];
      inv_q <= 1'b0;
    end else if (bus.wr && bus.addr == CDC_ADDR_CFG) begin
      cfg_q <= bus.wdata[1:0];
    end else if (bus.wr && bus.addr == CDC_ADDR_CTRL) begin
      inv_q <= bus.wdata[CDC_CTRL_INV];
    end
  end
  logic tclk_s;
  logic tfall;
  // sampled timer clock, to spot the falling edge the block latches on
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tclk_s <= 1'b0;
    end else begin
      tclk_s <= timer_clk_prescaled;
    end
  end
  assign tfall = tclk_s && !timer_clk_prescaled;
  sequence s_cfg_rd; bus.rd && bus.addr == CDC_ADDR_CFG; endsequence
  sequence s_ctrl_rd; bus.rd && bus.addr == CDC_ADDR_CTRL; endsequence
  sequence s_ctrl_wr; bus.wr && bus.addr == CDC_ADDR_CTRL; endsequence
  chk_gate_pin_sel: assert property (cfg_q[1] |-> timer_gate == timer_gate_pin)
    else $error("gate not from pin");
  chk_gate_cmp_sel: assert property (!cfg_q[1] |-> timer_gate == comparator_result)
    else $error("gate not from result");
  chk_direct_result: assert property (!cfg_q[0]
    |-> comparator_result == (cmp_raw ^ inv_q))
    else $error("direct result wrong");
  chk_cfg_read: assert property (s_cfg_rd |=> rdata == {6'h00, cfg_q})
    else $error("config readback wrong");
  chk_ctrl_read: assert property (s_ctrl_rd
    |=> !rdata[7] && !rdata[5] && rdata[4] == inv_q)
    else $error("control readback wrong");
  chk_mode_write: assert property (s_ctrl_wr
    |=> comparator_mode_code == $past(bus.wdata[2:0]))
    else $error("mode not taken");
  chk_pin_mux: assert property ($past(comparator_mode_code == 3'h1 || comparator_mode_code == 3'h3)
    |-> result_output_pin == $past(cmp_raw ^ inv_q))
    else $error("pin not raw result");
  chk_oe_dir: assert property (result_output_pin_oe_n == pin_direction[CDC_DIR_PIN])
    else $error("pin enable wrong");
  // other modes hand the port latch through, one cycle late
  chk_pin_latch: assert property (!$past(rst) &&
    $past(comparator_mode_code != 3'h1 && comparator_mode_code != 3'h3)
    |-> result_output_pin == $past(port_latch_bit))
    else $error("pin not port latch");
  // synced result takes the inverted raw value at a timer clock fall
  chk_sync_latch: assert property (cfg_q[0] && $past(tfall)
    |-> comparator_result == $past(cmp_raw ^ inv_q))
    else $error("synced result not latched");
  chk_sync_hold: assert property (cfg_q[0] && $past(cfg_q[0]) && !$past(tfall)
    |-> $stable(comparator_result))
    else $error("synced result moved off edge");
endmodule
bind cdc_comparator_control cdc_sva chk_u (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
  .cmp_raw(cmp_raw), .comparator_mode_code(comparator_mode_code),
  .input_switch(input_switch), .timer_gate_pin(timer_gate_pin),
  .timer_clk_prescaled(timer_clk_prescaled), .timer_gate(timer_gate),
  .comparator_result(comparator_result), .port_latch_bit(port_latch_bit),
  .result_output_pin(result_output_pin),
  .result_output_pin_oe_n(result_output_pin_oe_n), .pin_direction(pin_direction));

// ### testbench/cdc_analog_model.sv
// partner: analog comparator core and a free-running prescaled timer clock
module cdc_analog_model
  import cdc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // input levels and mode
  input wire logic [3:0] vin_n,
  input wire logic [3:0] vin_p,
  input wire logic [2:0] comparator_mode_code,
  // to the block
  output logic cmp_raw,
  output logic timer_clk
);
  logic [2:0] div_q;
  // one cycle of response delay; reset mode keeps the core quiet
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmp_raw <= 1'b0;
      div_q <= 3'h0;
    end else begin
      cmp_raw <= (comparator_mode_code != CDC_MODE_RESET) && (vin_n < vin_p);
      div_q <= div_q + 3'h1;
    end
  end
  assign timer_clk = div_q[2];
endmodule

// ### testbench/comparator_digital_control_bench.sv
// bench: register traffic, flag, interrupt, pin and reference checks
module comparator_digital_control_bench import cdc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, pend = 0, tpin = 0, pbit = 0, slp = 0;
  logic cmp_raw, tclk, tgate, res, opin, oe_n, irq, wake, wvec, asleep, isw;
  logic [3:0] vin_n = 4'h8, vin_p = 4'h0;
  logic [7:0] rdata, v;
  logic [2:0] mode;
  logic [5:0] dir;
  logic [31:0] lfsr = 32'h042e;
  cdc_bus_t bus_s = '0;
  cdc_ref_t vref;
  logic [7:0] exp_q[$];
  int n_fail = 0, check_count = 0, cyc = 0;
  always #20 mclk = ~mclk;
  cdc_comparator_control dut_u (.mclk(mclk), .rst(rst), .bus(bus_s), .rdata(rdata),
    .cmp_raw(cmp_raw), .comparator_mode_code(mode), .input_switch(isw),
    .internal_reference_level(vref), .timer_clk_prescaled(tclk), .timer_gate_pin(tpin),
    .timer_gate(tgate), .comparator_result(res), .port_latch_bit(pbit),
    .result_output_pin(opin), .result_output_pin_oe_n(oe_n), .pin_direction(dir),
    .sleep_req(slp), .irq_req(irq), .wake(wake), .wake_vector_en(wvec), .asleep(asleep));
  cdc_analog_model model_u (.mclk(mclk), .rst(rst), .vin_n(vin_n), .vin_p(vin_p),
    .comparator_mode_code(mode), .cmp_raw(cmp_raw), .timer_clk(tclk));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // stimulus source: one step of the bench's shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one-cycle sleep request; the pending flag wakes the block straight away
  task automatic doze(input logic e_vec);
    @(posedge mclk);
    slp <= 1'b1;
    @(posedge mclk);
    slp <= 1'b0;
    @(negedge mclk);
    chk("asleep", 8'h01, {7'h0, asleep});
    chk("wake", 8'h01, {7'h0, wake});
    chk("vector", {7'h0, e_vec}, {7'h0, wvec});
  endtask
  // one bus cycle; a read notes its expected data for the monitor
  task automatic op(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_s <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w) exp_q.push_back(d);
    @(posedge mclk);
    bus_s <= '0;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge mclk) begin
    if (pend) chk("rdata", exp_q.pop_front(), rdata);
    pend <= bus_s.rd;
    lfsr <= lfsr_next(lfsr);
    tpin <= lfsr[0];
    pbit <= lfsr[1];
  end
  // hang guard, generous against the roughly 185 cycles of traffic
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    op(0, CDC_ADDR_CFG, CDC_CFG_RST);
    op(0, CDC_ADDR_CTRL, 8'h00);
    op(0, CDC_ADDR_VREF, 8'h00);
    op(0, 10'h3fc, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = lfsr[15:8];
      op(1, CDC_ADDR_CFG, v);
      op(0, CDC_ADDR_CFG, v & CDC_CFG_MASK);
    end
    op(1, CDC_ADDR_CFG, 8'h00);
    op(1, CDC_ADDR_CTRL, 8'h41);
    op(0, CDC_ADDR_CTRL, 8'h01);
    op(1, CDC_ADDR_CTRL, 8'h11);
    op(0, CDC_ADDR_CTRL, 8'h51);
    op(1, CDC_ADDR_DIR, 8'h3b);
    @(negedge mclk);
    chk("oe_n", 8'h00, {7'h0, oe_n});
    chk("pin", 8'h01, {7'h0, opin});
    op(1, CDC_ADDR_PFLAG, 8'h00);
    op(0, CDC_ADDR_PFLAG, 8'h00);
    vin_p <= 4'hf;
    repeat (4) @(posedge mclk);
    op(0, CDC_ADDR_PFLAG, 8'h08);
    op(1, CDC_ADDR_PFLAG, 8'h00);
    op(0, CDC_ADDR_PFLAG, 8'h08);
    op(0, CDC_ADDR_CTRL, 8'h11);
    op(1, CDC_ADDR_PFLAG, 8'h00);
    op(0, CDC_ADDR_PFLAG, 8'h00);
    op(1, CDC_ADDR_PFLAG, 8'h08);
    op(0, CDC_ADDR_PFLAG, 8'h08);
    op(1, CDC_ADDR_PEN, 8'h08);
    op(1, CDC_ADDR_INTERRUPT_CONTROL_REG, 8'h40);
    @(negedge mclk);
    chk("irq", 8'h00, {7'h0, irq});
    op(1, CDC_ADDR_INTERRUPT_CONTROL_REG, 8'hc0);
    @(negedge mclk);
    chk("irq", 8'h01, {7'h0, irq});
    doze(1'b1);
    op(0, CDC_ADDR_CTRL, 8'h11);
    op(1, CDC_ADDR_INTERRUPT_CONTROL_REG, 8'h40);
    doze(1'b0);
    op(1, CDC_ADDR_VREF, 8'hff);
    @(negedge mclk);
    chk("vref", 8'h7e, {1'b0, vref});
    op(0, CDC_ADDR_VREF, 8'haf);
    op(1, CDC_ADDR_VREF, 8'h20);
    @(negedge mclk);
    chk("ground", 8'h01, {7'h0, vref.ground});
    op(1, CDC_ADDR_CTRL, 8'h0f);
    @(negedge mclk);
    chk("mode", {5'h0, CDC_MODE_OFF}, {5'h0, mode});
    chk("switch", 8'h01, {7'h0, isw});
    op(0, CDC_ADDR_CTRL, 8'h4f);
    // random input levels, first direct then synced to the timer clock
    for (int i = 0; i < 2; i++) begin
      op(1, CDC_ADDR_CFG, {7'h0, i[0]});
      op(0, CDC_ADDR_CFG, {7'h0, i[0]});
      repeat (40) begin
        @(posedge mclk);
        vin_p <= lfsr[7:4];
      end
    end
    repeat (2) @(posedge mclk);
    summarize();
  end
endmodule
